// *** core/logic_trigger_evaluator.sv ***
// Four-channel Boolean trigger evaluator with AXI4-Lite programming port.
// Comparator levels and the external clock and reset arrive asynchronously.
`timescale 1ns/1ps

// Summary of operation
// R1: Comparator high means channel true, low means false.
// R2: Each function is the OR of two product terms.
// R3: A term may AND any subset of the four channels.
// R4: Each used channel has a true or complemented polarity per term.
// R5: Unused channels have no effect on a term.
// R6: Each term may mark one channel edge-sensitive, rising or falling.
// R7: Edge term is true only in the cycle of the chosen transition.
// R8: In nested mode function A sets an armed state.
// R9: In nested mode B cannot trigger before arming.
// R10: A trigger pulse issues when the selected expression is satisfied.
// R11: Display switching is chopped or alternates after each sweep.
// R12: External reset high blocks trigger and clears the armed state.
// R13: With qualify on, triggers occur only at external clock edges.
// R14: A and B are separate programs; clear erases the selected one.
// R15: Edges compare the sample with the previous cycle's level.
// R16: The trigger is a single-cycle registered pulse.
module logic_trigger_evaluator
#(
  parameter int unsigned CHANNELS = trig_pkg::NUM_CH
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [CHANNELS-1:0] comp_in,
  input wire logic ext_clock_in,
  input wire logic ext_reset_in,
  input wire logic sweep_done,
  output logic trigger_out,
  output logic armed,
  output logic [CHANNELS-1:0] display_select,
  input wire logic [trig_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [trig_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import trig_pkg::*;

  // Elaboration check: the term layout is fixed at four channels
  if (CHANNELS != NUM_CH)
    $error("CHANNELS must be 4");

  typedef struct packed {
    logic [CHANNELS-1:0] ch_s1;
    logic [CHANNELS-1:0] ch_s2;
    logic [CHANNELS-1:0] ch_prev;
    logic [2:0] ext_clk_s;
    logic [1:0] ext_rst_s;
    logic [2:0] sweep_s;
    logic [31:0] func_a;
    logic [31:0] func_b;
    logic [11:0] ctrl;
    logic armed;
    logic trig;
    logic hit_prev;
    logic [CHANNELS-1:0] disp;
    logic aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic [CHANNELS-1:0] rise_w;
  logic [CHANNELS-1:0] fall_w;
  logic [1:0] term_a;
  logic [1:0] term_b;
  logic fa;
  logic fb;
  logic ext_edge;
  logic ext_rst;
  logic [31:0] wmask;
  logic [31:0] wval;

  // Edges against last cycle's registered level
  // R15: previous-sample compare
  assign rise_w = st_r.ch_s2 & ~st_r.ch_prev;
  assign fall_w = ~st_r.ch_s2 & st_r.ch_prev;
  assign ext_edge = st_r.ext_clk_s[1] & ~st_r.ext_clk_s[2];
  assign ext_rst = st_r.ext_rst_s[1];

  // Evaluate one product term; unused channels drop out of the AND
  function automatic logic eval_term(input logic [TERM_W-1:0] t,
                                     input logic [NUM_CH-1:0] lvl,
                                     input logic [NUM_CH-1:0] rs,
                                     input logic [NUM_CH-1:0] fl);
    logic [NUM_CH-1:0] match;
    logic [1:0] ec;
    logic edge_ok;
    match = ~(lvl ^ t[T_POL +: NUM_CH]) | ~t[T_USE +: NUM_CH];
    ec = t[T_EDGE_CH +: 2];
    edge_ok = t[T_EDGE_RISE] ? rs[ec] : fl[ec];
    if (t[T_USE +: NUM_CH] == '0)
      eval_term = 1'b0; // Empty term never fires
    else if (t[T_EDGE_EN])
      eval_term = edge_ok && ((match | (NUM_CH'(1) << ec)) == '1);
    else
      eval_term = (match == '1);
  endfunction

  // Per-term evaluation of both functions
  // R2: two products per function
  // R3: any channel subset
  // R4: per-channel polarity
  // R5: unused channels ignored
  // R6: one edge channel per term
  // R7: edge-qualified product
  // R1: comparator high is true
  generate
    for (genvar g = 0; g < NUM_TERMS; g++)
    begin : g_term
      assign term_a[g] = eval_term(st_r.func_a[g*TERM_W +: TERM_W],
                                   st_r.ch_s2, rise_w, fall_w);
      assign term_b[g] = eval_term(st_r.func_b[g*TERM_W +: TERM_W],
                                   st_r.ch_s2, rise_w, fall_w);
    end
  endgenerate

  assign fa = |term_a;
  assign fb = |term_b;

  // Write merge under byte strobes
  assign wmask = {{8{st_r.w_strb[3]}}, {8{st_r.w_strb[2]}},
                  {8{st_r.w_strb[1]}}, {8{st_r.w_strb[0]}}};
  assign wval = st_r.w_data & wmask;

  // Next state: synchronisers, trigger logic, bus slave
  always_comb
  begin
    logic hit;
    hit = 1'b0;
    st_nxt = st_r;
    st_nxt.ch_s1 = comp_in;
    st_nxt.ch_s2 = st_r.ch_s1;
    st_nxt.ch_prev = st_r.ch_s2;
    st_nxt.ext_clk_s = {st_r.ext_clk_s[1:0], ext_clock_in};
    st_nxt.ext_rst_s = {st_r.ext_rst_s[0], ext_reset_in};
    st_nxt.sweep_s = {st_r.sweep_s[1:0], sweep_done};

    // Select expression by mode
    // R10: pulse on satisfied expression
    unique case (st_r.ctrl[CTRL_MODE_LO +: 2])
      MODE_A: hit = fa;
      MODE_B: hit = fb;
      // R9: B blocked until armed
      MODE_NEST: hit = st_r.armed && fb;
      default: hit = 1'b0;
    endcase
    // R13: only at external clock edge
    if ((st_r.ctrl[CTRL_EXTQ] && !ext_edge) || ext_rst)
      hit = 1'b0;

    // Arming; firing consumes the arm so the next trigger needs A again
    // R8: A sets armed
    if (st_r.ctrl[CTRL_MODE_LO +: 2] != MODE_NEST)
      st_nxt.armed = 1'b0;
    else if (hit)
      st_nxt.armed = 1'b0;
    else if (fa)
      st_nxt.armed = 1'b1;

    // R16: one-cycle registered pulse
    // In modes A and B without qualify, a held expression fires once, not for as long as it stands
    st_nxt.trig = hit && !st_r.hit_prev;
    st_nxt.hit_prev = hit;
    // R12: external reset also clears the armed state
    if (ext_rst)
      st_nxt.armed = 1'b0;

    // Display channel rotation
    // R11: chop or alternate
    if (st_r.ctrl[CTRL_DEN_LO +: NUM_CH] == '0)
      st_nxt.disp = '0;
    else if (st_r.ctrl[CTRL_DISP] || (st_r.sweep_s[1] && !st_r.sweep_s[2])
             || (st_r.disp & st_r.ctrl[CTRL_DEN_LO +: NUM_CH]) == '0)
    begin
      st_nxt.disp = '0;
      for (int k = NUM_CH; k >= 1; k--)
        if (st_r.ctrl[CTRL_DEN_LO + ((k + onehot_idx(st_r.disp)) % NUM_CH)])
          st_nxt.disp = NUM_CH'(1) << ((k + onehot_idx(st_r.disp)) % NUM_CH);
    end

    // Write address and data accepted in either order
    if (s_axi_awvalid && !st_r.aw_have)
    begin
      st_nxt.aw_have = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_have)
    begin
      st_nxt.w_have = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    if (st_r.bvalid && s_axi_bready)
      st_nxt.bvalid = 1'b0;
    if (st_r.aw_have && st_r.w_have && !st_r.bvalid)
    begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      unique case ({st_r.aw_addr[ADDR_W-1:2], 2'b00})
        OFS_CTRL: st_nxt.ctrl = (st_r.ctrl & ~wmask[11:0]) | wval[11:0];
        OFS_FUNC_A: st_nxt.func_a = (st_r.func_a & ~wmask) | wval;
        OFS_FUNC_B: st_nxt.func_b = (st_r.func_b & ~wmask) | wval;
        OFS_STATUS: ;
        OFS_CMD:
        begin
          // R14: clear selected function
          if (wval[CMD_CLEAR] && !st_r.ctrl[CTRL_SEL])
            st_nxt.func_a = FUNC_RESET;
          else if (wval[CMD_CLEAR])
            st_nxt.func_b = FUNC_RESET;
        end
        default: st_nxt.bresp = RESP_SLVERR;
      endcase
    end

    // Read channel
    if (st_r.rvalid && s_axi_rready)
      st_nxt.rvalid = 1'b0;
    if (s_axi_arvalid && !st_r.rvalid)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RESP_OKAY;
      unique case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
        OFS_CTRL: st_nxt.rdata = {20'h0_0000, st_r.ctrl};
        OFS_FUNC_A: st_nxt.rdata = st_r.func_a;
        OFS_FUNC_B: st_nxt.rdata = st_r.func_b;
        OFS_STATUS: st_nxt.rdata = {22'h00_0000, st_r.disp, st_r.ch_s2,
                                    st_r.armed, ext_rst};
        OFS_CMD: st_nxt.rdata = 32'h0000_0000;
        default:
        begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  // Index of the one-hot display select, zero when none
  function automatic int unsigned onehot_idx(input logic [NUM_CH-1:0] v);
    onehot_idx = 0;
    for (int i = 0; i < NUM_CH; i++)
      if (v[i])
        onehot_idx = i;
  endfunction

  // Single state register; clock enable freezes everything
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_r <= '0;
    else if (clk_en)
      st_r <= st_nxt;
  end

  assign trigger_out = st_r.trig;
  assign armed = st_r.armed;
  assign display_select = st_r.disp;
  assign s_axi_awready = !st_r.aw_have;
  assign s_axi_wready = !st_r.w_have;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;

  // R16: trigger never two cycles long
  property p_pulse;
    @(posedge aclk) disable iff (!aresetn)
    clk_en && st_r.trig |=> !st_r.trig;
  endproperty
  a_pulse: assert property (p_pulse) else $error("trigger mis-timed"); // R16
  property p_ext_rst;
    @(posedge aclk) disable iff (!aresetn)
    clk_en && ext_rst |=> !st_r.trig && !st_r.armed;
  endproperty
  a_ext_rst: assert property (p_ext_rst) else $error("reset leak"); // R12
  property p_nest;
    @(posedge aclk) disable iff (!aresetn)
    clk_en && st_r.ctrl[1:0] == MODE_NEST && !st_r.armed
      |=> !st_r.trig;
  endproperty
  a_nest: assert property (p_nest) else $error("unarmed B fired"); // R9
  property p_arm;
    @(posedge aclk) disable iff (!aresetn)
    clk_en && st_r.ctrl[1:0] == MODE_NEST && fa && !ext_rst
      && !st_nxt.hit_prev |=> st_r.armed;
  endproperty
  a_arm: assert property (p_arm) else $error("A did not arm"); // R8
  property p_mode_a;
    @(posedge aclk) disable iff (!aresetn)
    clk_en && st_r.ctrl[3:0] == {2'b00, MODE_A} && fa && !ext_rst
      && !st_r.hit_prev |=> st_r.trig;
  endproperty
  a_mode_a: assert property (p_mode_a) else $error("A missed"); // R10
  property p_extq;
    @(posedge aclk) disable iff (!aresetn)
    clk_en && st_r.ctrl[CTRL_EXTQ] && !ext_edge |=> !st_r.trig;
  endproperty
  a_extq: assert property (p_extq) else $error("unqualified trig"); // R13
  property p_edge;
    @(posedge aclk) disable iff (!aresetn)
    st_r.func_a[T_EDGE_EN] && rise_w == '0 && fall_w == '0
      |-> !term_a[0];
  endproperty
  a_edge: assert property (p_edge) else $error("edge term on level"); // R7
  property p_unused;
    @(posedge aclk) disable iff (!aresetn)
    st_r.func_a[T_USE +: NUM_CH] == '0 |-> !term_a[0];
  endproperty
  a_unused: assert property (p_unused) else $error("empty term true"); // R5
endmodule

// *** core/trig_pkg.sv ***
// Constants shared by the trigger evaluator: register map and field layout.
// Assumes an AXI4-Lite master with 32-bit data in front of the block.
package trig_pkg;
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned NUM_TERMS = 2;
  localparam int unsigned ADDR_W = 6;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_FUNC_A = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_FUNC_B = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_CMD = 6'h10;
  // Control fields
  localparam int unsigned CTRL_MODE_LO = 0; // 2 bits: 0 A, 1 B, 2 A then B
  localparam int unsigned CTRL_SEL = 2;     // Function picked by clear
  localparam int unsigned CTRL_EXTQ = 3;    // External clock qualify
  localparam int unsigned CTRL_DISP = 4;    // Display switch mode (1 chop)
  localparam int unsigned CTRL_DEN_LO = 8;  // 4 bits display enables
  localparam int unsigned CMD_CLEAR = 0;
  // Product term layout inside a 16-bit half of a function word
  localparam int unsigned TERM_W = 16;
  localparam int unsigned T_USE = 0;   // 4 bits: channel used
  localparam int unsigned T_POL = 4;   // 4 bits: 1 true level, 0 complement
  localparam int unsigned T_EDGE_EN = 8;
  localparam int unsigned T_EDGE_CH = 9; // 2 bits
  localparam int unsigned T_EDGE_RISE = 11;
  localparam logic [1:0] MODE_A = 2'h0;
  localparam logic [1:0] MODE_B = 2'h1;
  localparam logic [1:0] MODE_NEST = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] FUNC_RESET = 32'h0000_0000;
endpackage

// *** tb/time_base_model.sv ***
// Behavioural time base that consumes trigger pulses.
// Assumes the trigger is registered on aclk; ends each sweep with a flag.
`timescale 1ns/1ps
module time_base_model
#(
  parameter int SWEEP_LEN = 10
)
(
  input wire logic aclk,
  input wire logic trigger_in,
  output logic sweep_done,
  output int trig_count
);
  logic prev_r = 1'b0;
  int left_r = 0;

  initial sweep_done = 1'b0;
  initial trig_count = 0;

  // Count trigger starts; a held trigger counts once
  always @(posedge aclk)
  begin
    prev_r <= trigger_in;
    if (trigger_in === 1'b1 && prev_r !== 1'b1)
      trig_count <= trig_count + 1;
    if (left_r == 0 && trigger_in === 1'b1)
      left_r <= SWEEP_LEN;
    else if (left_r > 0)
      left_r <= left_r - 1;
    sweep_done <= (left_r == 1); // Low again outside the sweep end
  end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the trigger evaluator.
// Assumes trig_pkg and the time base model are compiled first.
`timescale 1ns/1ps
module testbench;
  import trig_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, ext_clk = 1'b0, ext_rst = 1'b0;
  logic [3:0] comp = 4'h0;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, trig, armed, sweep;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] disp;
  int err_total = 0, n_checks = 0, trig_cnt, n;
  logic [3:0] d0;

  // Free-running evaluation clock
  always #10 aclk = ~aclk;

  logic_trigger_evaluator dut (.aclk(aclk), .aresetn(aresetn),
    .clk_en(1'b1), .comp_in(comp), .ext_clock_in(ext_clk),
    .ext_reset_in(ext_rst), .sweep_done(sweep), .trigger_out(trig),
    .armed(armed), .display_select(disp), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  time_base_model tbm (.aclk(aclk), .trigger_in(trig),
    .sweep_done(sweep), .trig_count(trig_cnt));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (err_total == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
      k++;
    end
    while (bvalid !== 1'b1 && k < 50);
    bready <= 1'b0;
    chk(bvalid, 1'b1);
    chk(bresp, RESP_OKAY);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] e,
                    input logic [1:0] r);
    int k;
    k = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
      k++;
    end
    while (rvalid !== 1'b1 && k < 50);
    rready <= 1'b0;
    chk(rvalid, 1'b1);
    chk(rdata, e);
    chk(rresp, r);
  endtask

  // Set the comparator levels, then count trigger starts over a window
  task automatic see(input logic [3:0] c, input int cyc);
    int c0;
    @(posedge aclk);
    comp <= c;
    c0 = trig_cnt;
    repeat (cyc) @(posedge aclk);
    n = trig_cnt - c0;
  endtask

  task automatic regs_reset();
    rd(OFS_CTRL, 32'h0, RESP_OKAY);
    rd(OFS_FUNC_A, FUNC_RESET, RESP_OKAY);
    rd(6'h14, 32'h0, RESP_SLVERR);
  endtask

  task automatic level_terms();
    wr(OFS_CTRL, 32'h0);
    wr(OFS_FUNC_A, 32'h0000_0013);
    see(4'b0011, 8);
    chk(n, 0);
    see(4'b1101, 8);
    chk(n != 0, 1);
    see(4'b1100, 8);
    chk(n, 0);
    see(4'b0000, 4);
    wr(OFS_FUNC_A, 32'h0088_0013);
    rd(OFS_FUNC_A, 32'h0088_0013, RESP_OKAY);
    see(4'b1000, 8);
    chk(n != 0, 1);
  endtask

  task automatic edge_term();
    see(4'b0001, 4);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_FUNC_B, 32'h0000_0D11);
    see(4'b0001, 8);
    chk(n, 0);
    see(4'b0101, 8);
    chk(n, 1);
    see(4'b0001, 8);
    chk(n, 0);
  endtask

  task automatic nested();
    wr(OFS_FUNC_A, 32'h0000_0022);
    wr(OFS_CTRL, 32'h2);
    see(4'b0101, 8);
    chk(n, 0);
    see(4'b0111, 8);
    chk(armed, 1'b1);
    see(4'b0001, 8);
    see(4'b0101, 8);
    chk(n, 1);
    see(4'b0011, 8);
    chk(armed, 1'b1);
    // external reset from the outside party
    ext_rst <= 1'b1;
    see(4'b0111, 8);
    chk(armed, 1'b0);
    chk(n, 0);
    ext_rst <= 1'b0;
  endtask

  task automatic clear_func();
    wr(OFS_CTRL, 32'h4);
    wr(OFS_CMD, 32'h1);
    rd(OFS_FUNC_B, FUNC_RESET, RESP_OKAY);
    rd(OFS_FUNC_A, 32'h0000_0022, RESP_OKAY);
  endtask

  task automatic ext_qual();
    see(4'b0000, 4);
    wr(OFS_CTRL, 32'h8);
    see(4'b0010, 10);
    chk(n, 0);
    ext_clk <= 1'b1;
    see(4'b0010, 8);
    chk(n != 0, 1);
    ext_clk <= 1'b0;
  endtask

  task automatic display();
    wr(OFS_CTRL, 32'h0000_0510);
    repeat (6)
    begin
      @(posedge aclk);
      chk(disp == 4'b0001 || disp == 4'b0100, 1'b1);
    end
    // Alternate: the sweep end from the time base moves the display on
    wr(OFS_CTRL, 32'h0000_0500);
    see(4'b0000, 30);
    d0 = disp;
    see(4'b0010, 30);
    chk(disp, d0 ^ 4'b0101);
  endtask

  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    regs_reset();
    level_terms();
    edge_term();
    nested();
    clear_func();
    ext_qual();
    display();
    test_done();
  end

  // Watchdog far beyond the expected run length
  initial
  begin
    #100000;
    err_total++;
    test_done();
  end
endmodule
